// >>> hw/iepp_cfg.svh
// Offsets, field positions and reset values of the interrupt register slice.
`ifndef IEPP_CFG_SVH
`define IEPP_CFG_SVH

// ----------------------------------------------------------------------------
// Sizes and field positions
// ----------------------------------------------------------------------------
`define IEPP_NUM_IRQ         32
`define IEPP_ADDR_W          12
`define IEPP_DATA_W          32
`define IEPP_PRIO_W          2
`define IEPP_LANE_W          8
`define IEPP_LANES           4
`define IEPP_PRIO_LSB        6

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IEPP_OFS_ENABLE_SET  12'h100
`define IEPP_OFS_ENABLE_CLR  12'h180
`define IEPP_OFS_PEND_SET    12'h200
`define IEPP_OFS_PEND_CLR    12'h280
`define IEPP_OFS_SENSE_MODE  12'h300
`define IEPP_OFS_ACTIVE      12'h304
`define IEPP_OFS_PRIO_BASE   12'h400

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IEPP_RST_ENABLE      32'h00000000
`define IEPP_RST_PENDING     32'h00000000
`define IEPP_RST_SENSE_MODE  32'h00000000
`define IEPP_RST_PRIO        2'h0

`endif

// >>> hw/iepp_pkg.sv
// Types shared by the interrupt register slice.
`include "iepp_cfg.svh"
package iepp_pkg;
  typedef logic [`IEPP_PRIO_W-1:0] iepp_prio_t;
  typedef logic [`IEPP_ADDR_W-1:0] iepp_addr_t;
  typedef logic [`IEPP_DATA_W-1:0] iepp_word_t;
endpackage

// >>> hw/iepp_select.sv
// Picks the highest-priority candidate interrupt.
`timescale 1ns/1ns
`default_nettype none
`include "iepp_cfg.svh"
module iepp_select
  import iepp_pkg::*;
#(
  parameter int NUM_IRQ = `IEPP_NUM_IRQ,
  parameter int ID_W    = $clog2(NUM_IRQ)
) (
  input  wire logic [NUM_IRQ-1:0]             cand,
  input  wire logic [NUM_IRQ*`IEPP_PRIO_W-1:0] prio_flat,
  output logic                                found,
  output logic [ID_W-1:0]                     best_id,
  output iepp_prio_t                          best_prio
);

  // ----------------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------------
  // Lower value wins; on a tie the lower interrupt number wins.
  always_comb begin
    found     = 1'b0;
    best_id   = '0;
    best_prio = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (cand[i] && (!found || prio_flat[i*`IEPP_PRIO_W +: `IEPP_PRIO_W] < best_prio)) begin
        found     = 1'b1;
        best_id   = ID_W'(i);
        best_prio = prio_flat[i*`IEPP_PRIO_W +: `IEPP_PRIO_W];
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/iepp_top.sv
// Interrupt enable, pending, active and priority register slice with request capture.
//
// Behaviour
// - Enable-set write of one enables that interrupt; reads show enabled interrupts.
// - A pending and enabled interrupt is offered to the core by its priority.
// - Disabled interrupts still become pending but are never offered to the core.
// - Enable-clear write of one disables that interrupt; reads show enabled state.
// - Pending-set write of one makes that interrupt pending; reads show pending state.
// - Pending-set on a pending interrupt changes nothing; disabled ones still pend.
// - Pending-clear write of one removes pending state; reads show pending state.
// - Pending-clear writes never alter the active state.
// - Eight priority words hold two bits per interrupt, full-word access only.
// - Each priority word holds four byte fields; lower value means higher priority.
// - Only bits 7:6 of each field are kept; bits 5:0 read zero.
// - Interrupt M lives in priority word M/4, byte lane M mod 4.
// - Each request input may be level-sensitive or pulse.
// - Pulse inputs are sampled on each rising clock edge and latched as pending.
// - Entering an interrupt's service routine clears its pending state.
// - A level line still high at routine return makes the interrupt pending again.
// - Rising edge, or active line while not active, makes the interrupt pending.
// - A pulse during the routine makes it pending and active, pending after exit.
// - Pending-clear on a level interrupt with its line still high changes nothing.
`timescale 1ns/1ns
`default_nettype none
`include "iepp_cfg.svh"
module iepp_top
  import iepp_pkg::*;
#(
  parameter int NUM_IRQ = `IEPP_NUM_IRQ,
  parameter int ID_W    = $clog2(NUM_IRQ)
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [NUM_IRQ-1:0] irq_req,
  input  wire iepp_addr_t         addr,
  input  wire iepp_word_t         wdata,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output iepp_word_t              rdata,
  input  wire logic               isr_enter,
  input  wire logic [ID_W-1:0]    isr_enter_id,
  input  wire logic               isr_return,
  input  wire logic [ID_W-1:0]    isr_return_id,
  output logic                    take_valid,
  output logic [ID_W-1:0]         take_id,
  output iepp_prio_t              take_prio,
  output logic [NUM_IRQ-1:0]      irq_enabled,
  output logic [NUM_IRQ-1:0]      irq_pending,
  output logic [NUM_IRQ-1:0]      irq_active
);

  // Four interrupts share each priority word, one per byte lane.
  localparam int PRIO_WORDS = NUM_IRQ / `IEPP_LANES;
  localparam int PI_W       = (PRIO_WORDS > 1) ? $clog2(PRIO_WORDS) : 1;

  // ----------------------------------------------------------------------------
  // Request synchronisers and edge detection
  // ----------------------------------------------------------------------------
  logic [NUM_IRQ-1:0] req_meta;
  logic [NUM_IRQ-1:0] req_sync;
  logic [NUM_IRQ-1:0] req_prev;
  logic [NUM_IRQ-1:0] req_rise;

  // Request lines arrive from outside the clock domain, so two flops settle them first.
  // Only the second flop is read, which adds two cycles before a request can pend.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_meta <= '0;
      req_sync <= '0;
    end else begin
      req_meta <= irq_req;
      req_sync <= req_meta;
    end
  end

  // The previous sample is taken every rising edge, so a one-cycle pulse is seen.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_prev <= '0;
    end else begin
      req_prev <= req_sync;
    end
  end

  // The previous sample resets low like an idle pin, so reset never fakes a rise.
  assign req_rise = req_sync & ~req_prev;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  iepp_addr_t        prio_offset;
  logic [PI_W-1:0]   prio_index;
  logic              prio_hit;
  logic              wr_enable_set;
  logic              wr_enable_clr;
  logic              wr_pend_set;
  logic              wr_pend_clr;
  logic              wr_sense_mode;
  logic              wr_prio;

  // Priority words sit at consecutive word offsets from their base. Unaligned or
  // unmapped addresses hit nothing, so writes there are dropped and reads give zero.
  assign prio_offset   = addr - `IEPP_OFS_PRIO_BASE;
  assign prio_index    = prio_offset[PI_W+1:2];
  assign prio_hit      = (addr >= `IEPP_OFS_PRIO_BASE)
                      && (prio_offset < NUM_IRQ)
                      && (prio_offset[1:0] == 2'h0);
  assign wr_enable_set = wr_en && (addr == `IEPP_OFS_ENABLE_SET);
  assign wr_enable_clr = wr_en && (addr == `IEPP_OFS_ENABLE_CLR);
  assign wr_pend_set   = wr_en && (addr == `IEPP_OFS_PEND_SET);
  assign wr_pend_clr   = wr_en && (addr == `IEPP_OFS_PEND_CLR);
  assign wr_sense_mode = wr_en && (addr == `IEPP_OFS_SENSE_MODE);
  assign wr_prio       = wr_en && prio_hit;

  // ----------------------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------------------
  // One strobe carries one address, so a set and a clear never meet in one cycle.
  logic [NUM_IRQ-1:0] enabled;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enabled <= NUM_IRQ'(`IEPP_RST_ENABLE);
    end else if (wr_enable_set) begin
      enabled <= enabled | wdata[NUM_IRQ-1:0];
    end else if (wr_enable_clr) begin
      enabled <= enabled & ~wdata[NUM_IRQ-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Sense mode register
  // ----------------------------------------------------------------------------
  // A one selects pulse detection, a zero level detection.
  logic [NUM_IRQ-1:0] pulse_mode;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulse_mode <= NUM_IRQ'(`IEPP_RST_SENSE_MODE);
    end else if (wr_sense_mode) begin
      pulse_mode <= wdata[NUM_IRQ-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Priority fields
  // ----------------------------------------------------------------------------
  iepp_prio_t                      prio [NUM_IRQ];
  logic [NUM_IRQ*`IEPP_PRIO_W-1:0] prio_flat;

  // Only the top two bits of each byte lane are stored; the other bits read zero.
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_prio
    localparam int LANE = g % `IEPP_LANES;
    localparam int MSB  = LANE * `IEPP_LANE_W + `IEPP_LANE_W - 1;

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        prio[g] <= `IEPP_RST_PRIO;
      end else if (wr_prio && (prio_index == PI_W'(g / `IEPP_LANES))) begin
        prio[g] <= wdata[MSB -: `IEPP_PRIO_W];
      end
    end

    assign prio_flat[g*`IEPP_PRIO_W +: `IEPP_PRIO_W] = prio[g];
  end

  // ----------------------------------------------------------------------------
  // Pending and active state
  // ----------------------------------------------------------------------------
  // A level line pends whenever it is high and its routine is not running. A pulse line
  // pends on each rising edge, even during its routine, so a second pulse is not lost.
  logic [NUM_IRQ-1:0] pending;
  logic [NUM_IRQ-1:0] active;
  logic [NUM_IRQ-1:0] next_pending;
  logic [NUM_IRQ-1:0] next_active;

  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_state
    logic enter_g;
    logic return_g;
    logic level_set_g;
    logic hw_set_g;
    logic sw_set_g;
    logic sw_clr_g;

    assign enter_g  = isr_enter && (isr_enter_id == ID_W'(g));
    assign return_g = isr_return && (isr_return_id == ID_W'(g));

    // A level line held high while the routine runs must not pend until return.
    assign level_set_g = req_sync[g] && ((!active[g] && !enter_g) || return_g);
    assign hw_set_g    = pulse_mode[g] ? req_rise[g] : level_set_g;
    assign sw_set_g    = wr_pend_set && wdata[g];

    // A clear is ignored while a level line still asks for service.
    assign sw_clr_g = wr_pend_clr && wdata[g]
                   && (pulse_mode[g] || !req_sync[g]);

    // Any set beats a clear arriving in the same cycle.
    always_comb begin
      if (hw_set_g || sw_set_g) begin
        next_pending[g] = 1'b1;
      end else if (enter_g || sw_clr_g) begin
        next_pending[g] = 1'b0;
      end else begin
        next_pending[g] = pending[g];
      end
    end

    // Only routine entry and return move the active state.
    always_comb begin
      if (enter_g) begin
        next_active[g] = 1'b1;
      end else if (return_g) begin
        next_active[g] = 1'b0;
      end else begin
        next_active[g] = active[g];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending <= NUM_IRQ'(`IEPP_RST_PENDING);
    end else begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  // ----------------------------------------------------------------------------
  // Offer to the core
  // ----------------------------------------------------------------------------
  // The offer is registered and trails the pending and enable state by one cycle.
  // Active interrupts that pend again stay candidates; preemption is left to the core.
  logic [NUM_IRQ-1:0] cand;
  logic               sel_found;
  logic [ID_W-1:0]    sel_id;
  iepp_prio_t         sel_prio;

  assign cand = pending & enabled;

  iepp_select #(
    .NUM_IRQ (NUM_IRQ),
    .ID_W    (ID_W)
  ) u_select (
    .cand      (cand),
    .prio_flat (prio_flat),
    .found     (sel_found),
    .best_id   (sel_id),
    .best_prio (sel_prio)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      take_valid <= 1'b0;
      take_id    <= '0;
      take_prio  <= '0;
    end else begin
      take_valid <= sel_found;
      take_id    <= sel_id;
      take_prio  <= sel_prio;
    end
  end

  // ----------------------------------------------------------------------------
  // State outputs
  // ----------------------------------------------------------------------------
  // Copies of the internal state, one cycle late, so that each output leaves a flop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_enabled <= '0;
      irq_pending <= '0;
      irq_active  <= '0;
    end else begin
      irq_enabled <= enabled;
      irq_pending <= pending;
      irq_active  <= active;
    end
  end

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  // Reads are decoded from the current state; unmapped addresses return zero.
  iepp_word_t next_rdata;

  always_comb begin
    int idx;
    idx        = 0;
    next_rdata = '0;
    if (prio_hit) begin
      for (int l = 0; l < `IEPP_LANES; l++) begin
        idx = int'(prio_index) * `IEPP_LANES + l;
        next_rdata[l*`IEPP_LANE_W + `IEPP_PRIO_LSB +: `IEPP_PRIO_W] = prio[idx];
      end
    end else begin
      unique case (addr)
        `IEPP_OFS_ENABLE_SET: begin
          next_rdata[NUM_IRQ-1:0] = enabled;
        end
        `IEPP_OFS_ENABLE_CLR: begin
          next_rdata[NUM_IRQ-1:0] = enabled;
        end
        `IEPP_OFS_PEND_SET: begin
          next_rdata[NUM_IRQ-1:0] = pending;
        end
        `IEPP_OFS_PEND_CLR: begin
          next_rdata[NUM_IRQ-1:0] = pending;
        end
        `IEPP_OFS_SENSE_MODE: begin
          next_rdata[NUM_IRQ-1:0] = pulse_mode;
        end
        `IEPP_OFS_ACTIVE: begin
          next_rdata[NUM_IRQ-1:0] = active;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// >>> verification/iepp_top_asserts.sv
// Concurrent checks on the ports of the interrupt register slice.
`timescale 1ns/1ns
`default_nettype none
module iepp_top_chk
  import iepp_pkg::*;
#(
  parameter int NUM_IRQ = 32,
  parameter int ID_W    = 5
) (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire iepp_addr_t         addr,
  input wire iepp_word_t         wdata,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire iepp_word_t         rdata,
  input wire logic               isr_enter,
  input wire logic [ID_W-1:0]    isr_enter_id,
  input wire logic               isr_return,
  input wire logic [ID_W-1:0]    isr_return_id,
  input wire logic               take_valid,
  input wire logic [ID_W-1:0]    take_id,
  input wire iepp_prio_t         take_prio,
  input wire logic [NUM_IRQ-1:0] irq_enabled,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  en_set_a: assert property (wr_en && addr == 12'h100 |-> ##2
    (irq_enabled & $past(wdata, 2)) == $past(wdata, 2)) else $error("enable set lost");
  en_clr_a: assert property (wr_en && addr == 12'h180 |-> ##2
    (irq_enabled & $past(wdata, 2)) == '0) else $error("enable clear lost");
  pend_set_a: assert property (wr_en && addr == 12'h200 |-> ##2
    (irq_pending & $past(wdata, 2)) == $past(wdata, 2)) else $error("pending set lost");
  act_keep_a: assert property (wr_en && addr == 12'h280 && !isr_enter && !isr_return
    |-> ##2 $stable(irq_active)) else $error("pending clear moved active");
  offer_match_a: assert property (take_valid == |(irq_enabled & irq_pending))
    else $error("offer differs from enabled pending set");
  offer_legal_a: assert property (take_valid |-> irq_enabled[take_id]
    && irq_pending[take_id]) else $error("offered interrupt not enabled and pending");
  prio_zero_a: assert property (rd_en && addr[11:5] == 7'h20 |=>
    (rdata & 32'h3F3F3F3F) == '0) else $error("unused priority bits not zero");
  enter_act_a: assert property (isr_enter && !isr_return |-> ##2
    irq_active[$past(isr_enter_id, 2)]) else $error("entered interrupt not active");
  pulse_pend_a: assert property ($rose(irq_req[0]) ##0
    (!isr_enter && !wr_en && !irq_active[0])[*5] |-> ##[0:3] irq_pending[0])
    else $error("request not latched");
  pend_act_c: cover property (irq_pending[0] && irq_active[0]);
  reentry_c: cover property (isr_return ##[1:12] isr_enter);
  prio_rd_c: cover property (rd_en && addr[11:5] == 7'h20);
endmodule
bind iepp_top iepp_top_chk #(.NUM_IRQ(NUM_IRQ), .ID_W(ID_W)) i_iepp_top_chk (
  .clk(clk), .reset(reset), .irq_req(irq_req), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .isr_enter(isr_enter),
  .isr_enter_id(isr_enter_id), .isr_return(isr_return), .isr_return_id(isr_return_id),
  .take_valid(take_valid), .take_id(take_id), .take_prio(take_prio),
  .irq_enabled(irq_enabled), .irq_pending(irq_pending), .irq_active(irq_active));
`default_nettype wire

// >>> verification/iepp_core_model.sv
// Core model: takes the offered interrupt, runs its routine, then returns.
`timescale 1ns/1ns
`default_nettype none
module iepp_core_model
  import iepp_pkg::*;
#(
  parameter int ID_W = 5
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            run,
  input  wire logic            slow,
  input  wire logic            take_valid,
  input  wire logic [ID_W-1:0] take_id,
  output logic                 isr_enter,
  output logic [ID_W-1:0]      isr_enter_id,
  output logic                 isr_return,
  output logic [ID_W-1:0]      isr_return_id
);
  logic [ID_W-1:0] cur;
  logic            busy;
  int              cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {isr_enter, isr_return, busy, cur, isr_enter_id, isr_return_id} <= '0;
      cnt <= 0;
    end else begin
      isr_enter <= 1'h0;
      isr_return <= 1'h0;
      // Idle ids toggle so that a stale id is never read as a live one.
      isr_enter_id <= ~isr_enter_id;
      isr_return_id <= ~isr_return_id;
      if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        isr_return <= 1'h1;
        isr_return_id <= cur;
        busy <= 1'h0;
        cnt <= 4;
      end else if (run && take_valid) begin
        isr_enter <= 1'h1;
        isr_enter_id <= take_id;
        cur <= take_id;
        busy <= 1'h1;
        cnt <= slow ? 12 : 3;
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/test_iepp_top.sv
// Self-checking bench for the interrupt enable, pending and priority slice.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_iepp_top
  import iepp_pkg::*;
;
  logic        clk = 1'h0, reset = 1'h1, wr_en = 1'h0, rd_en = 1'h0, run = 1'h0, slow = 1'h0;
  logic [31:0] irq_req = '0, irq_enabled, irq_pending, irq_active, m_en = '0, m_pd = '0, w;
  iepp_addr_t  addr = '0;
  iepp_word_t  wdata = '0, rdata;
  logic        isr_enter, isr_return, take_valid;
  logic [4:0]  isr_enter_id, isr_return_id, take_id;
  iepp_prio_t  take_prio;
  int          miscompares = 0, num_checks = 0, seed = 45565, m_pr[32], ent[32], bi, bp;
  logic [11:0] offs[7] = '{12'h100, 12'h180, 12'h200, 12'h280, 12'h300, 12'h304, 12'h008};
  always #5 clk = ~clk;
  always @(posedge clk) if (isr_enter) ent[isr_enter_id]++;
  iepp_top i_iepp_top (.clk(clk), .reset(reset), .irq_req(irq_req), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .isr_enter(isr_enter),
    .isr_enter_id(isr_enter_id), .isr_return(isr_return), .isr_return_id(isr_return_id),
    .take_valid(take_valid), .take_id(take_id), .take_prio(take_prio),
    .irq_enabled(irq_enabled), .irq_pending(irq_pending), .irq_active(irq_active));
  iepp_core_model i_iepp_core_model (.clk(clk), .reset(reset), .run(run), .slow(slow),
    .take_valid(take_valid), .take_id(take_id), .isr_enter(isr_enter),
    .isr_enter_id(isr_enter_id), .isr_return(isr_return), .isr_return_id(isr_return_id));
  task automatic wr(input logic [11:0] a, input iepp_word_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input iepp_word_t e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_out();
    bi = -1;
    bp = 4;
    for (int i = 0; i < 32; i++)
      if (m_en[i] && m_pd[i] && m_pr[i] < bp) begin
        bi = i;
        bp = m_pr[i];
      end
    `CHK("irq_enabled", m_en, irq_enabled)
    `CHK("irq_pending", m_pd, irq_pending)
    `CHK("take_valid", bi >= 0, take_valid)
    if (bi >= 0) `CHK("take_id", 5'(bi), take_id)
    if (bi >= 0) `CHK("take_prio", 2'(bp), take_prio)
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    m_pr = '{default: 0};
    ent = '{default: 0};
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    foreach (offs[i]) rd(offs[i], '0);
    for (int k = 0; k < 8; k++) rd(12'(12'h400 + 4 * k), '0);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      w = $random(seed);
      wr(k[0] ? 12'h180 : 12'h100, w);
      m_en = k[0] ? m_en & ~w : m_en | w;
      rd(12'h100, m_en);
      rd(12'h180, m_en);
    end
    $display("test enables done");
    for (int k = 0; k < 8; k++) begin
      w = $random(seed);
      wr(12'(12'h400 + 4 * k), w);
      for (int l = 0; l < 4; l++) m_pr[4 * k + l] = w[8 * l + 6 +: 2];
      rd(12'(12'h400 + 4 * k), w & 32'hC0C0C0C0);
    end
    $display("test priorities done");
    for (int k = 0; k < 6; k++) begin
      w = $random(seed);
      wr(12'h200, w);
      wr(12'h200, w);
      m_pd = m_pd | w;
      rd(12'h280, m_pd);
      w = $random(seed);
      wr(12'h280, w);
      m_pd = m_pd & ~w;
      rd(12'h200, m_pd);
      wait_cy(3);
      chk_out();
      `CHK("irq_active", 32'h0, irq_active)
    end
    wr(12'h280, 32'hFFFFFFFF);
    $display("test pending and offer done");
    wr(12'h300, 32'h00000001);
    rd(12'h300, 32'h00000001);
    wr(12'h100, 32'hFFFFFFFF);
    run <= 1'h1;
    irq_req[0] <= 1'h1;
    @(posedge clk);
    irq_req[0] <= 1'h0;
    wait_cy(30);
    `CHK("enters", 1, ent[0])
    `CHK("irq_pending", 32'h0, irq_pending)
    @(posedge clk);
    slow <= 1'h1;
    irq_req[0] <= 1'h1;
    @(posedge clk);
    irq_req[0] <= 1'h0;
    repeat (8) @(posedge clk);
    irq_req[0] <= 1'h1;
    @(posedge clk);
    irq_req[0] <= 1'h0;
    wr(12'h280, 32'h00000002);
    wait_cy(3);
    `CHK("pend_act", 1'h1, irq_pending[0] & irq_active[0])
    rd(12'h304, 32'h00000001);
    wait_cy(60);
    `CHK("enters", 3, ent[0])
    @(posedge clk);
    slow <= 1'h0;
    irq_req[9] <= 1'h1;
    wait_cy(40);
    `CHK("reentry", 1'h1, ent[9] > 1)
    @(posedge clk);
    irq_req[9] <= 1'h0;
    wait_cy(30);
    rd(12'h200, '0);
    @(posedge clk);
    run <= 1'h0;
    irq_req[9] <= 1'h1;
    wait_cy(6);
    wr(12'h280, 32'h00000200);
    wait_cy(2);
    rd(12'h200, 32'h00000200);
    @(posedge clk);
    irq_req[9] <= 1'h0;
    wait_cy(4);
    wr(12'h280, 32'h00000200);
    rd(12'h280, '0);
    $display("test requests done");
    @(posedge clk);
    reset <= 1'h1;
    @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(12'h100, '0);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
